// ---- bench/fsto_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module fsto_core_model
	import fsto_pkg::*;
(
	input wire logic clk, // System clock.
	input wire logic [7:0] reg_rdata, // Read data from the block.
	output var fsto_bus_s bus // Register accesses towards the block.
);
	initial begin
		bus = '0;
	end

	// Idle address and data are inverted so a stale value never looks like a live request.
	task automatic access(input logic is_wr, input logic [11:0] addr, input logic [7:0] wdata);
		@(posedge clk);
		bus <= '{wr: is_wr, rd: !is_wr, addr: addr, wdata: wdata};
		@(posedge clk);
		bus <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
	endtask : access

	task automatic wr_reg(input logic [11:0] addr, input logic [7:0] data);
		access(1'b1, addr, data);
	endtask : wr_reg

	task automatic rd_reg(input logic [11:0] addr, output logic [7:0] data);
		access(1'b0, addr, 8'h00);
		@(posedge clk);
		#1;
		data = reg_rdata;
	endtask : rd_reg

	task automatic trim_wr(input logic [7:0] idx, input logic [7:0] data);
		wr_reg(FSTO_ADDR_TRIM_IDX, idx);
		wr_reg(FSTO_ADDR_TRIM_DATA, data);
	endtask : trim_wr

	task automatic trim_rd(input logic [7:0] idx, output logic [7:0] data);
		wr_reg(FSTO_ADDR_TRIM_IDX, idx);
		rd_reg(FSTO_ADDR_TRIM_DATA, data);
	endtask : trim_rd
endmodule : fsto_core_model

`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb
	import fsto_pkg::*;
;
	logic clk, rst_n, por_n, wdog_timeout, wdog_sw_enable;
	fsto_bus_s bus;
	fsto_op_s op_busy;
	fsto_prog_s prog;
	logic [FSTO_TRIM_BITS-1:0] factory_trim, trim_working, exp_trim;
	logic [7:0] reg_rdata, erase_page_select, sector_protect, user_option_byte, user_option_byte1;
	logic [15:0] erase_page_base;
	logic [1:0] osc_source_select;
	logic flash_unlocked, wdog_timeout_action, wdog_always_on, brownout_always_on;
	logic read_protect_bit, write_protect_bit, wdog_irq, wdog_sys_reset, wdog_enable;
	int err_count = 0;
	int check_count = 0;
	int cycles = 0;

	fsto_top i_fsto_top (.clk(clk), .rst_n(rst_n), .por_n(por_n), .bus(bus),
		.reg_rdata(reg_rdata), .op_busy(op_busy), .prog(prog), .factory_trim(factory_trim),
		.wdog_timeout(wdog_timeout), .wdog_sw_enable(wdog_sw_enable),
		.erase_page_select(erase_page_select), .erase_page_base(erase_page_base),
		.sector_protect(sector_protect), .flash_unlocked(flash_unlocked),
		.trim_working(trim_working), .user_option_byte(user_option_byte),
		.user_option_byte1(user_option_byte1),
		.wdog_timeout_action(wdog_timeout_action), .wdog_always_on(wdog_always_on),
		.osc_source_select(osc_source_select), .brownout_always_on(brownout_always_on),
		.read_protect_bit(read_protect_bit), .write_protect_bit(write_protect_bit),
		.wdog_irq(wdog_irq), .wdog_sys_reset(wdog_sys_reset), .wdog_enable(wdog_enable));

	fsto_core_model i_fsto_core_model (.clk(clk), .reg_rdata(reg_rdata), .bus(bus));

	// ------------------------------------------------------------------
	// Clock, timeout and reporting
	// ------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// The whole sequence needs well under a thousand cycles.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			final_report();
		end
	end

	task automatic final_report();
		$display("Checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic chk_trim(input string what);
		check_count++;
		if (trim_working !== exp_trim) begin
			err_count++;
			$display("Error at %0t: %s working trim differs", $time, what);
		end
	endtask : chk_trim

	task automatic step();
		@(posedge clk);
		#1;
	endtask : step

	task automatic wd_pulse(input logic exp_irq);
		@(posedge clk);
		wdog_timeout <= 1'b1;
		@(posedge clk);
		wdog_timeout <= 1'b0;
		#1;
		chk({wdog_irq, wdog_sys_reset}, {exp_irq, !exp_irq}, "watchdog action");
		step();
		chk({wdog_irq, wdog_sys_reset}, 16'h0, "watchdog pulse width");
	endtask : wd_pulse

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_lock_and_page();
		logic [7:0] d;
		i_fsto_core_model.rd_reg(FSTO_ADDR_STATE, d);
		chk(d, 16'h00, "status locked");
		chk(flash_unlocked, 16'h0, "locked flag");
		i_fsto_core_model.wr_reg(FSTO_ADDR_PAGE, 8'h12);
		step();
		chk(erase_page_select, 16'h12, "page while locked");
		i_fsto_core_model.rd_reg(FSTO_ADDR_PAGE, d);
		chk(d, 16'h12, "page select read");
		i_fsto_core_model.wr_reg(FSTO_ADDR_STATE, FSTO_UNLOCK_1);
		i_fsto_core_model.rd_reg(FSTO_ADDR_STATE, d);
		chk(d, 16'h01, "status first byte");
		i_fsto_core_model.wr_reg(FSTO_ADDR_STATE, FSTO_UNLOCK_2);
		i_fsto_core_model.rd_reg(FSTO_ADDR_STATE, d);
		chk(d, 16'h03, "status unlocked");
		chk(flash_unlocked, 16'h1, "unlocked flag");
		i_fsto_core_model.wr_reg(FSTO_ADDR_STATE, FSTO_SPR_SELECT);
		i_fsto_core_model.rd_reg(FSTO_ADDR_STATE, d);
		chk(d, 16'h04, "status protect selected");
		i_fsto_core_model.wr_reg(FSTO_ADDR_PAGE, 8'h05);
		step();
		chk({erase_page_select, sector_protect}, 16'h1205, "protect write");
		i_fsto_core_model.wr_reg(FSTO_ADDR_STATE, 8'h00);
		i_fsto_core_model.wr_reg(FSTO_ADDR_PAGE, 8'h83);
		step();
		chk(erase_page_select, 16'h83, "page after deselect");
		chk(erase_page_base, 16'h0600, "page base");
	endtask : t_lock_and_page

	task automatic t_trim();
		logic [7:0] d;
		i_fsto_core_model.trim_wr(FSTO_TRIM_IDX_MAX, 8'h5A);
		step();
		exp_trim[255:248] = 8'h5A;
		chk_trim("trim write");
		i_fsto_core_model.trim_rd(FSTO_TRIM_IDX_MAX, d);
		chk(d, 16'h5A, "trim read");
		i_fsto_core_model.rd_reg(FSTO_ADDR_TRIM_DATA, d);
		chk(d, 16'h5A, "trim index kept");
		i_fsto_core_model.trim_rd(8'h00, d);
		chk(d, {8'h00, exp_trim[7:0]}, "trim read first");
		i_fsto_core_model.trim_wr(8'h20, 8'h77);
		i_fsto_core_model.rd_reg(FSTO_ADDR_TRIM_DATA, d);
		chk(d, 16'h00, "trim beyond range");
		chk_trim("trim beyond range");
		i_fsto_core_model.rd_reg(FSTO_ADDR_TRIM_IDX, d);
		chk(d, 16'h20, "trim index read");
	endtask : t_trim

	task automatic t_option();
		chk(wdog_enable, 16'h0, "erased watchdog off");
		@(posedge clk);
		prog <= '{wr: 1'b1, addr: FSTO_OPT_ADDR0, data: 8'h3A};
		@(posedge clk);
		prog <= '{wr: 1'b1, addr: FSTO_OPT_ADDR1, data: 8'hA5};
		@(posedge clk);
		prog <= '{wr: 1'b0, addr: 16'hFFFF, data: 8'hC5};
		step();
		step();
		chk(user_option_byte, 16'h3A, "option programmed");
		chk(user_option_byte1, 16'hA5, "option byte one programmed");
		chk({wdog_timeout_action, wdog_always_on, osc_source_select, brownout_always_on,
			read_protect_bit, write_protect_bit}, 16'h1C, "option fields");
		chk(wdog_enable, 16'h1, "watchdog forced on");
		wd_pulse(1'b1);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) step();
		exp_trim = factory_trim;
		chk_trim("trim after reset");
		chk({user_option_byte, user_option_byte1}, 16'h3AA5, "option after reset");
	endtask : t_option

	task automatic t_ops();
		logic [7:0] d;
		logic [5:0] code [3] = '{FSTO_ST_PROG, FSTO_ST_PAGE, FSTO_ST_MASS};
		i_fsto_core_model.wr_reg(FSTO_ADDR_PAGE, 8'h01);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			op_busy <= fsto_op_s'(3'(1 << i));
			i_fsto_core_model.rd_reg(FSTO_ADDR_STATE, d);
			chk(d, {10'h000, code[i]}, "status busy");
			if (i == 1)
				chk(user_option_byte, 16'h3A, "option after other page");
			@(posedge clk);
			op_busy <= '0;
		end
		repeat (2) step();
		chk({user_option_byte, user_option_byte1}, 16'hFFFF, "option after mass erase");
		chk_trim("trim after mass erase");
		wd_pulse(1'b0);
	endtask : t_ops

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		por_n = 1'b0;
		op_busy = '0;
		prog = '0;
		wdog_timeout = 1'b0;
		wdog_sw_enable = 1'b0;
		for (int i = 0; i < FSTO_TRIM_COUNT; i++)
			factory_trim[8*i +: 8] = 8'hC0 + 8'(i);
		exp_trim = factory_trim;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		por_n <= 1'b1;
		repeat (2) step();
		t_lock_and_page();
		t_trim();
		t_option();
		t_ops();
		final_report();
	end
endmodule : tb

`default_nettype wire

// ---- rtl/fsto_opt.sv ----
`timescale 1ns/1ps
`default_nettype none

module fsto_opt
	import fsto_pkg::*;
(
	input wire logic clk, // System clock.
	input wire logic por_n, // Power-on reset, active low; loads the erased value.
	input wire fsto_prog_s prog, // Program memory byte write.
	input wire logic erase_p0, // Page zero or mass erase started.
	output logic [7:0] opt0, // Option byte at program address 0000H.
	output logic [7:0] opt1 // Option byte at program address 0001H.
);

	typedef struct packed {
		logic [7:0] b0;
		logic [7:0] b1;
	} fsto_opt_s;

	fsto_opt_s opt_reg;
	fsto_opt_s opt_next;

	// Flash cells only clear on programming and only set on erase, so a
	// program write is an AND with the stored byte.
	always_comb begin
		opt_next = opt_reg;
		if (erase_p0) begin
			opt_next.b0 = FSTO_ERASED;
			opt_next.b1 = FSTO_ERASED;
		end else if (prog.wr && prog.addr == FSTO_OPT_ADDR0) begin
			opt_next.b0 = opt_reg.b0 & prog.data;
		end else if (prog.wr && prog.addr == FSTO_OPT_ADDR1) begin
			opt_next.b1 = opt_reg.b1 & prog.data;
		end
	end

	// System reset does not reach this store; only power-on does.
	always_ff @(posedge clk or negedge por_n) begin
		if (!por_n) begin
			opt_reg <= {FSTO_ERASED, FSTO_ERASED};
		end else begin
			opt_reg <= opt_next;
		end
	end

	assign opt0 = opt_reg.b0;
	assign opt1 = opt_reg.b1;

endmodule : fsto_opt

`default_nettype wire

// ---- rtl/fsto_pkg.sv ----
package fsto_pkg;

	// ------------------------------------------------------------------
	// Register file addresses
	// ------------------------------------------------------------------
	localparam logic [11:0] FSTO_ADDR_TRIM_IDX = 12'hFF6;
	localparam logic [11:0] FSTO_ADDR_TRIM_DATA = 12'hFF7;
	localparam logic [11:0] FSTO_ADDR_STATE = 12'hFF8;
	localparam logic [11:0] FSTO_ADDR_PAGE = 12'hFF9;

	// ------------------------------------------------------------------
	// Control bytes and status codes
	// ------------------------------------------------------------------
	localparam logic [7:0] FSTO_UNLOCK_1 = 8'h73;
	localparam logic [7:0] FSTO_UNLOCK_2 = 8'h8C;
	localparam logic [7:0] FSTO_SPR_SELECT = 8'h5E;
	localparam logic [5:0] FSTO_ST_LOCKED = 6'h00;
	localparam logic [5:0] FSTO_ST_FIRST = 6'h01;
	localparam logic [5:0] FSTO_ST_SECOND = 6'h02;
	localparam logic [5:0] FSTO_ST_UNLOCKED = 6'h03;
	localparam logic [5:0] FSTO_ST_SPR = 6'h04;
	localparam logic [5:0] FSTO_ST_PROG = 6'h08;
	localparam logic [5:0] FSTO_ST_PAGE = 6'h10;
	localparam logic [5:0] FSTO_ST_MASS = 6'h20;
	localparam logic [7:0] FSTO_RST_BYTE = 8'h00;

	// ------------------------------------------------------------------
	// Pages, trim store and option bytes
	// ------------------------------------------------------------------
	localparam int FSTO_PAGE_OFS_BITS = 9;
	localparam int FSTO_TRIM_COUNT = 32;
	localparam int FSTO_TRIM_BITS = FSTO_TRIM_COUNT * 8;
	localparam logic [7:0] FSTO_TRIM_IDX_MAX = 8'h1F;
	localparam logic [15:0] FSTO_OPT_ADDR0 = 16'h0000;
	localparam logic [15:0] FSTO_OPT_ADDR1 = 16'h0001;
	localparam logic [7:0] FSTO_ERASED = 8'hFF;
	localparam int FSTO_OPT_WD_ACTION = 7;
	localparam int FSTO_OPT_WD_AO = 6;
	localparam int FSTO_OPT_OSC_HI = 5;
	localparam int FSTO_OPT_OSC_LO = 4;
	localparam int FSTO_OPT_BO_AO = 3;
	localparam int FSTO_OPT_RD_PROT = 2;
	localparam int FSTO_OPT_WR_PROT = 0;

	typedef enum logic [2:0] {
		FSTO_LOCKED,
		FSTO_FIRST,
		FSTO_SECOND,
		FSTO_UNLOCKED,
		FSTO_SPR_SEL
	} fsto_lock_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [7:0] wdata;
	} fsto_bus_s;

	typedef struct packed {
		logic mass_erase;
		logic page_erase;
		logic prog;
	} fsto_op_s;

	typedef struct packed {
		logic wr;
		logic [15:0] addr;
		logic [7:0] data;
	} fsto_prog_s;

endpackage : fsto_pkg

// ---- rtl/fsto_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module fsto_top
	import fsto_pkg::*;
(
	input wire logic clk, // System clock, 10 MHz.
	input wire logic rst_n, // System reset, asynchronous, active low.
	input wire logic por_n, // Power-on reset, asynchronous, active low.
	input wire fsto_bus_s bus, // Register file access from the core.
	output logic [7:0] reg_rdata, // Read data, valid the cycle after a read.
	input wire fsto_op_s op_busy, // Operation running in the flash engine.
	input wire fsto_prog_s prog, // Program memory byte write.
	input wire logic [FSTO_TRIM_BITS-1:0] factory_trim, // Factory trim bytes.
	input wire logic wdog_timeout, // Watchdog timeout pulse.
	input wire logic wdog_sw_enable, // Software watchdog enable.
	output logic [7:0] erase_page_select, // Page select register.
	output logic [15:0] erase_page_base, // First address of the selected page.
	output logic [7:0] sector_protect, // Sector protect register.
	output logic flash_unlocked, // Controller unlocked.
	output logic [FSTO_TRIM_BITS-1:0] trim_working, // Working trim values.
	output logic [7:0] user_option_byte, // Option byte at address 0000H.
	output logic [7:0] user_option_byte1, // Option byte at address 0001H.
	output logic wdog_timeout_action, // 1: timeout resets, 0: interrupt.
	output logic wdog_always_on, // 0: watchdog cannot be disabled.
	output logic [1:0] osc_source_select, // Oscillator source.
	output logic brownout_always_on, // Brownout detector always on.
	output logic read_protect_bit, // Flash read protect.
	output logic write_protect_bit, // Flash write protect.
	output logic wdog_irq, // Watchdog interrupt request pulse.
	output logic wdog_sys_reset, // Watchdog system reset request pulse.
	output logic wdog_enable // Watchdog running.
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		fsto_lock_e lock;
		logic [7:0] page;
		logic [7:0] sprot;
		logic [7:0] trim_idx;
		logic [7:0] rdata;
		fsto_op_s op_q;
		logic erase_p0;
		logic [15:0] page_base;
		logic wd_irq;
		logic wd_rst;
		logic wd_en;
		logic unlocked;
	} fsto_ctl_s;

	fsto_ctl_s ctl_reg;
	fsto_ctl_s ctl_next;
	logic [5:0] state_code;
	logic trim_in_range;
	logic trim_wr;
	logic [7:0] trim_rdata;
	logic trim_loaded;
	logic [7:0] opt0;

	// ------------------------------------------------------------------
	// Status code
	// ------------------------------------------------------------------
	always_comb begin
		if (op_busy.mass_erase) begin
			state_code = FSTO_ST_MASS;
		end else if (op_busy.page_erase) begin
			state_code = FSTO_ST_PAGE;
		end else if (op_busy.prog) begin
			state_code = FSTO_ST_PROG;
		end else begin
			case (ctl_reg.lock)
				FSTO_LOCKED: state_code = FSTO_ST_LOCKED;
				FSTO_FIRST: state_code = FSTO_ST_FIRST;
				FSTO_SECOND: state_code = FSTO_ST_SECOND;
				FSTO_UNLOCKED: state_code = FSTO_ST_UNLOCKED;
				FSTO_SPR_SEL: state_code = FSTO_ST_SPR;
				default: state_code = FSTO_ST_LOCKED;
			endcase
		end
	end

	// Indices above the trim range are kept but reach nothing, so the rest of
	// the information page stays out of reach.
	assign trim_in_range = ctl_reg.trim_idx <= FSTO_TRIM_IDX_MAX;
	assign trim_wr = bus.wr && bus.addr == FSTO_ADDR_TRIM_DATA && trim_in_range;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		ctl_next = ctl_reg;
		ctl_next.op_q = op_busy;
		ctl_next.erase_p0 = 1'b0;
		if (bus.wr && bus.addr == FSTO_ADDR_STATE) begin
			case (ctl_reg.lock)
				FSTO_LOCKED: begin
					if (bus.wdata == FSTO_UNLOCK_1) begin
						ctl_next.lock = FSTO_FIRST;
					end
				end
				FSTO_FIRST: begin
					if (bus.wdata == FSTO_UNLOCK_2) begin
						ctl_next.lock = FSTO_SECOND;
					end else begin
						ctl_next.lock = FSTO_LOCKED;
					end
				end
				FSTO_UNLOCKED, FSTO_SPR_SEL: begin
					if (bus.wdata == FSTO_SPR_SELECT) begin
						ctl_next.lock = FSTO_SPR_SEL;
					end else begin
						ctl_next.lock = FSTO_UNLOCKED;
					end
				end
				default: ctl_next.lock = FSTO_LOCKED;
			endcase
		end else if (ctl_reg.lock == FSTO_SECOND) begin
			ctl_next.lock = FSTO_UNLOCKED;
		end
		// A finished operation locks the controller again.
		if ((|ctl_reg.op_q) && !(|op_busy)) begin
			ctl_next.lock = FSTO_LOCKED;
		end
		if (bus.wr && bus.addr == FSTO_ADDR_PAGE) begin
			if (ctl_reg.lock == FSTO_SPR_SEL) begin
				ctl_next.sprot = ctl_reg.sprot | bus.wdata;
			end else begin
				ctl_next.page = bus.wdata;
			end
		end
		ctl_next.page_base = {ctl_reg.page[6:0], {FSTO_PAGE_OFS_BITS{1'b0}}};
		if (bus.wr && bus.addr == FSTO_ADDR_TRIM_IDX) begin
			ctl_next.trim_idx = bus.wdata;
		end
		// Only the option bytes react to erases; trim and serial data are
		// outside the program array and are never touched here.
		if ((op_busy.page_erase && !ctl_reg.op_q.page_erase && ctl_reg.page[6:0] == 7'h00)
				|| (op_busy.mass_erase && !ctl_reg.op_q.mass_erase)) begin
			ctl_next.erase_p0 = 1'b1;
		end
		if (bus.rd) begin
			case (bus.addr)
				FSTO_ADDR_STATE: ctl_next.rdata = {2'b00, state_code};
				FSTO_ADDR_PAGE: ctl_next.rdata = ctl_reg.page;
				FSTO_ADDR_TRIM_IDX: ctl_next.rdata = ctl_reg.trim_idx;
				FSTO_ADDR_TRIM_DATA: begin
					ctl_next.rdata = trim_in_range ? trim_rdata : FSTO_RST_BYTE;
				end
				default: ctl_next.rdata = FSTO_RST_BYTE;
			endcase
		end
		ctl_next.wd_irq = wdog_timeout && !opt0[FSTO_OPT_WD_ACTION];
		ctl_next.wd_rst = wdog_timeout && opt0[FSTO_OPT_WD_ACTION];
		ctl_next.wd_en = !opt0[FSTO_OPT_WD_AO] || wdog_sw_enable;
		ctl_next.unlocked = ctl_next.lock == FSTO_UNLOCKED
				|| ctl_next.lock == FSTO_SPR_SEL;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_reg <= '0;
		end else begin
			ctl_reg <= ctl_next;
		end
	end

	// ------------------------------------------------------------------
	// Trim store and option bytes
	// ------------------------------------------------------------------
	fsto_trim u_trim (
		.clk(clk),
		.rst_n(rst_n),
		.factory_trim(factory_trim),
		.wr(trim_wr),
		.idx(ctl_reg.trim_idx[4:0]),
		.wdata(bus.wdata),
		.rdata(trim_rdata),
		.loaded(trim_loaded),
		.working(trim_working)
	);

	fsto_opt u_opt (
		.clk(clk),
		.por_n(por_n),
		.prog(prog),
		.erase_p0(ctl_reg.erase_p0),
		.opt0(opt0),
		.opt1(user_option_byte1)
	);

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign reg_rdata = ctl_reg.rdata;
	assign erase_page_select = ctl_reg.page;
	assign erase_page_base = ctl_reg.page_base;
	assign sector_protect = ctl_reg.sprot;
	assign flash_unlocked = ctl_reg.unlocked;
	assign user_option_byte = opt0;
	assign wdog_timeout_action = opt0[FSTO_OPT_WD_ACTION];
	assign wdog_always_on = opt0[FSTO_OPT_WD_AO];
	assign osc_source_select = opt0[FSTO_OPT_OSC_HI:FSTO_OPT_OSC_LO];
	assign brownout_always_on = opt0[FSTO_OPT_BO_AO];
	assign read_protect_bit = opt0[FSTO_OPT_RD_PROT];
	assign write_protect_bit = opt0[FSTO_OPT_WR_PROT];
	assign wdog_irq = ctl_reg.wd_irq;
	assign wdog_sys_reset = ctl_reg.wd_rst;
	assign wdog_enable = ctl_reg.wd_en;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	AST_STATUS_LOCKED: assert property (
		bus.rd && bus.addr == FSTO_ADDR_STATE && ctl_reg.lock == FSTO_LOCKED && !(|op_busy)
		|=> reg_rdata == 8'h00)
		else $error("Locked status did not read zero.");

	AST_UNLOCK_SEQ: assert property (
		ctl_reg.lock == FSTO_FIRST && !(|ctl_reg.op_q) && !(|op_busy) && bus.wr
		&& bus.addr == FSTO_ADDR_STATE && bus.wdata == 8'h8C
		|=> ctl_reg.lock == FSTO_SECOND ##1 (ctl_reg.lock == FSTO_UNLOCKED || $past(bus.wr)))
		else $error("Unlock sequence did not reach the unlocked state.");

	AST_SPR_CODE: assert property (
		bus.rd && bus.addr == FSTO_ADDR_STATE && ctl_reg.lock == FSTO_SPR_SEL && !(|op_busy)
		|=> reg_rdata == 8'h04)
		else $error("Sector protect selection not shown in status.");

	AST_MASS_CODE: assert property (
		bus.rd && bus.addr == FSTO_ADDR_STATE && op_busy.mass_erase
		|=> reg_rdata[5:3] == 3'h4)
		else $error("Mass erase not shown in status.");

	AST_PAGE_WR: assert property (
		bus.wr && bus.addr == FSTO_ADDR_PAGE && ctl_reg.lock != FSTO_SPR_SEL
		|=> erase_page_select == $past(bus.wdata) && $stable(sector_protect))
		else $error("Page select write went astray.");

	AST_SPR_WR: assert property (
		bus.wr && bus.addr == FSTO_ADDR_PAGE && ctl_reg.lock == FSTO_SPR_SEL
		|=> $stable(erase_page_select))
		else $error("Sector protect write changed page select.");

	AST_PAGE_BASE: assert property (
		bus.wr && bus.addr == FSTO_ADDR_PAGE && ctl_reg.lock != FSTO_SPR_SEL
		##1 !(bus.wr && bus.addr == FSTO_ADDR_PAGE)
		|=> erase_page_base == {$past(bus.wdata, 2) & 8'h7F, 8'h00} << 1)
		else $error("Erase page base does not follow page select.");

	AST_TRIM_WR: assert property (
		trim_wr && trim_loaded
		|=> trim_working[$past(ctl_reg.trim_idx[4:0])*8 +: 8] == $past(bus.wdata))
		else $error("Trim write did not reach the indexed byte.");

	AST_TRIM_RD: assert property (
		bus.rd && bus.addr == FSTO_ADDR_TRIM_DATA && trim_in_range
		|=> reg_rdata == $past(trim_working[ctl_reg.trim_idx[4:0]*8 +: 8]))
		else $error("Trim read returned the wrong byte.");

	AST_TRIM_RELOAD: assert property (
		!trim_loaded |=> trim_working == $past(factory_trim) && trim_loaded)
		else $error("Trim values not restored after reset.");

	AST_TRIM_RANGE: assert property (
		bus.rd && bus.addr == FSTO_ADDR_TRIM_DATA && !trim_in_range
		|=> reg_rdata == 8'h00)
		else $error("Out of range trim index returned data.");

	AST_OPT_ERASE: assert property (
		ctl_reg.erase_p0 && por_n |=> user_option_byte == 8'hFF && user_option_byte1 == 8'hFF)
		else $error("Page zero erase did not clear option bytes.");

	AST_WD_ACTION: assert property (
		wdog_timeout |=> wdog_irq == !wdog_sys_reset && wdog_sys_reset == $past(opt0[7]))
		else $error("Watchdog timeout took the wrong action.");

	AST_WD_AO: assert property (
		!wdog_always_on && $stable(wdog_always_on) |=> wdog_enable)
		else $error("Always-on watchdog was disabled.");

	COV_UNLOCKED: cover property (ctl_reg.lock == FSTO_SECOND ##1 ctl_reg.lock == FSTO_UNLOCKED);
	COV_SPR_SEL: cover property (ctl_reg.lock == FSTO_SPR_SEL && bus.wr
		&& bus.addr == FSTO_ADDR_PAGE);
	COV_TRIM_WR_RD: cover property (trim_wr ##[1:4] bus.rd && bus.addr == FSTO_ADDR_TRIM_DATA);
	COV_WD_RESET: cover property (wdog_sys_reset);

endmodule : fsto_top

`default_nettype wire

// ---- rtl/fsto_trim.sv ----
`timescale 1ns/1ps
`default_nettype none

module fsto_trim
	import fsto_pkg::*;
(
	input wire logic clk, // System clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic [FSTO_TRIM_BITS-1:0] factory_trim, // Factory bytes, entry 0 lowest.
	input wire logic wr, // Write strobe for the selected entry.
	input wire logic [4:0] idx, // Selected entry.
	input wire logic [7:0] wdata, // Write data.
	output logic [7:0] rdata, // Working value of the selected entry.
	output logic loaded, // Working copies hold valid values.
	output logic [FSTO_TRIM_BITS-1:0] working // All working values.
);

	typedef struct packed {
		logic loaded;
		logic [FSTO_TRIM_COUNT-1:0][7:0] val;
	} fsto_trim_s;

	fsto_trim_s trim_reg;
	fsto_trim_s trim_next;

	// The factory copy is reloaded after every reset release; the reset itself
	// may only load a constant, so one cycle passes before the copies are valid.
	always_comb begin
		trim_next = trim_reg;
		if (!trim_reg.loaded) begin
			trim_next.loaded = 1'b1;
			trim_next.val = factory_trim;
		end else if (wr) begin
			trim_next.val[idx] = wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trim_reg <= '0;
		end else begin
			trim_reg <= trim_next;
		end
	end

	for (genvar i = 0; i < FSTO_TRIM_COUNT; i++) begin : g_entry
		assign working[i*8 +: 8] = trim_reg.val[i];
	end

	assign rdata = trim_reg.val[idx];
	assign loaded = trim_reg.loaded;

endmodule : fsto_trim

`default_nettype wire
